// [hdl/dcp_pkg.sv]
package dcp_pkg;

   // geometry
   localparam int RANKS     = 2;
   localparam int LANES     = 8;
   localparam int LANE_W    = 8;
   localparam int ADDR_W    = 17;
   localparam int LP_CHANS  = 4;

   // command strobe positions on row_col_lines
   localparam int RAS_POS   = 16;
   localparam int CAS_POS   = 15;
   localparam int WE_POS    = 14;

   // reset values of pin groups
   localparam logic [1:0] CKE_RST   = 2'h0;
   localparam logic [1:0] ODT_RST   = 2'h0;
   localparam logic       VTT_RST   = 1'b0;

   // clock divider: memory clock toggles every DIV_HALF ref cycles
   localparam int DIV_HALF  = 1;

   // command kinds requested by the user side
   typedef enum logic [2:0] {
      DCP_NOP,
      DCP_ACT,
      DCP_RD,
      DCP_WR,
      DCP_PRE,
      DCP_MRS,
      DCP_REF
   } dcp_cmd_t;

   // request from controller core
   typedef struct packed {
      dcp_cmd_t            cmd;
      logic [1:0]          rank;
      logic [1:0]          group;
      logic [1:0]          bank;
      logic [ADDR_W-1:0]   addr;
   } dcp_req_t;

   // command/address pin group
   typedef struct packed {
      logic [ADDR_W-1:0]   row_col_lines;
      logic                command_kind_flag;
      logic [1:0]          group_select;
      logic [1:0]          array_select;
      logic [RANKS-1:0]    rank_select;
   } dcp_ca_t;

   // power state requests
   typedef struct packed {
      logic                self_refresh;
      logic                deep_idle;
      logic                suspend_to_ram;
      logic [RANKS-1:0]    power_down;
      logic                init_done;
   } dcp_pwr_t;

endpackage : dcp_pkg

// [hdl/dcp_pin_if.sv]
`timescale 1ns/10ps
// Function
// - ddr4: bits 16/15/14 carry RAS CAS WE
// - command flag high with select marks command
// - group_select names bank group, MRS
// - array_select names bank, MRS register
// - clock gate per rank: init, powerdown, self-refresh
// - one rank select per rank
// - lp5 rank select active high
// - one termination control per rank
// - termination supply low in deep idle/S3
// - ddr4 clock pair per rank
// - lp5 clock pair per channel
// - bidirectional strobe pair per byte lane
// - data as eight byte lanes
module dcp_pin_if #(
   parameter int RANKS  = dcp_pkg::RANKS,
   parameter int LANES  = dcp_pkg::LANES
) (
   // clock and reset
   input  wire logic                          i_ref_clk,
   input  wire logic                          i_arst_n,
   // mode: 1 = lp5, 0 = ddr4
   input  wire logic                          i_lp5_mode,
   // command request
   input  wire dcp_pkg::dcp_req_t             i_req,
   input  wire logic [RANKS-1:0]              i_odt_req,
   input  wire dcp_pkg::dcp_pwr_t             i_pwr,
   // write data and read data side
   input  wire logic                          i_wr_en,
   input  wire logic [LANES*8-1:0]            i_wr_data,
   output logic      [LANES*8-1:0]            o_rd_data,
   output logic                               o_rd_valid,
   // command/address, clock gate, termination and clock pins
   output dcp_pkg::dcp_ca_t                   o_ca,
   output logic      [RANKS-1:0]              o_rank_clk_gate,
   output logic      [RANKS-1:0]              o_termination_ctrl,
   output logic                               o_termination_supply_gate,
   output logic      [RANKS-1:0]              o_mem_clock_pair_p,
   output logic      [RANKS-1:0]              o_mem_clock_pair_n,
   output logic      [dcp_pkg::LP_CHANS-1:0]  o_lp_clock_pair_p,
   output logic      [dcp_pkg::LP_CHANS-1:0]  o_lp_clock_pair_n,
   // data lanes, three signals each
   input  wire logic [LANES-1:0][7:0]         i_data_lines,
   output logic      [LANES-1:0][7:0]         o_data_lines,
   output logic      [LANES-1:0]              o_data_lines_oe,
   // strobe pairs, sampled from the pins
   input  wire logic [LANES-1:0]              i_data_strobe_p,
   output logic      [LANES-1:0]              o_data_strobe_p,
   output logic      [LANES-1:0]              o_data_strobe_n,
   output logic      [LANES-1:0]              o_data_strobe_oe
);

   // refuse geometries the fixed pin structs cannot carry; the memory
   // clock divider is a single toggle flop, so only a half period of one works
   if (RANKS != 2 || LANES < 1 || LANES > 8 || dcp_pkg::DIV_HALF != 1) begin : g_bad_geometry
      $error("dcp_pin_if: unsupported RANKS or LANES");
   end

   // command decode into row_col_lines strobes
   function automatic logic [2:0] cmd_strobes(input dcp_pkg::dcp_cmd_t c);
      case (c)
         dcp_pkg::DCP_RD:  cmd_strobes = 3'h5; // RAS CAS WE (active low)
         dcp_pkg::DCP_WR:  cmd_strobes = 3'h4;
         dcp_pkg::DCP_PRE: cmd_strobes = 3'h2;
         dcp_pkg::DCP_MRS: cmd_strobes = 3'h0;
         dcp_pkg::DCP_REF: cmd_strobes = 3'h1;
         default:          cmd_strobes = 3'h7;
      endcase
   endfunction : cmd_strobes

   // registered pin state
   dcp_pkg::dcp_ca_t    ca_ff;
   logic [RANKS-1:0]    cke_ff;
   logic [RANKS-1:0]    odt_ff;
   logic                vtt_ff;
   logic                mclk_ff;
   // write path
   logic [LANES*8-1:0]  wdat_ff;
   logic                wr_ff;
   logic                wr_d_ff;

   // synchronisers for strobe input
   logic [LANES-1:0]    dqs_s1_ff;
   logic [LANES-1:0]    dqs_s2_ff;
   logic [LANES-1:0]    dqs_s3_ff;
   // data lanes, two flops
   logic [LANES*8-1:0]  dq_s1_ff;
   logic [LANES*8-1:0]  dq_s2_ff;
   // captured read word
   logic [LANES*8-1:0]  rdat_ff;
   logic                rvld_ff;
   // own strobe drive, delayed like the strobe samples
   logic                own_s1_ff;
   logic                own_s2_ff;

   // command assembly
   wire                 is_act    = (i_req.cmd == dcp_pkg::DCP_ACT);
   wire                 is_cmd    = (i_req.cmd != dcp_pkg::DCP_NOP);
   wire [2:0]           strobes   = cmd_strobes(i_req.cmd);
   wire [RANKS-1:0]     rank_hot  = is_cmd ? (RANKS'(1) << i_req.rank[0]) : '0;
   wire                 is_mrs    = (i_req.cmd == dcp_pkg::DCP_MRS);
   dcp_pkg::dcp_ca_t    nxt_ca;

   always_comb begin
      nxt_ca                   = '0;
      nxt_ca.row_col_lines     = i_req.addr;
      // upper bits become strobes for non-activate commands
      if (!is_act) begin
         nxt_ca.row_col_lines[dcp_pkg::RAS_POS] = strobes[2];
         nxt_ca.row_col_lines[dcp_pkg::CAS_POS] = strobes[1];
         nxt_ca.row_col_lines[dcp_pkg::WE_POS]  = strobes[0];
      end
      nxt_ca.command_kind_flag = !is_act;
      nxt_ca.group_select      = is_mrs ? {1'b0, i_req.group[0]} : i_req.group;
      nxt_ca.array_select      = i_req.bank;
      // ddr4 select is active low, lp5 active high
      nxt_ca.rank_select       = i_lp5_mode ? rank_hot : ~rank_hot;
   end

   // clock gate: off until init, off in self-refresh or power-down
   wire [RANKS-1:0] nxt_cke = (!i_pwr.init_done || i_pwr.self_refresh ||
                               i_pwr.suspend_to_ram) ? '0 : ~i_pwr.power_down;
   // regulator gate: off in deep idle and suspend
   wire nxt_vtt = !(i_pwr.deep_idle || i_pwr.suspend_to_ram);

   // command/control registers
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ca_ff  <= '0;
         cke_ff <= dcp_pkg::CKE_RST;
         odt_ff <= dcp_pkg::ODT_RST;
         vtt_ff <= dcp_pkg::VTT_RST;
      end else begin
         ca_ff  <= nxt_ca;
         cke_ff <= nxt_cke;
         odt_ff <= i_odt_req & nxt_cke;
         vtt_ff <= nxt_vtt;
      end
   end

   // memory clock from divider
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mclk_ff <= 1'b0;
      end else begin
         mclk_ff <= ~mclk_ff;
      end
   end

   // write data and lane enable
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wdat_ff <= '0;
         wr_ff   <= 1'b0;
         wr_d_ff <= 1'b0;
      end else begin
         wdat_ff <= i_wr_data;
         wr_ff   <= i_wr_en;
         wr_d_ff <= wr_ff;
      end
   end

   // drive flag pipeline, aligned with dqs_s1_ff and dqs_s2_ff
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         own_s1_ff <= 1'b0;
         own_s2_ff <= 1'b0;
      end else begin
         own_s1_ff <= wr_ff | wr_d_ff;
         own_s2_ff <= own_s1_ff;
      end
   end

   // read capture: sync strobe and data, take data on strobe rise
   wire [LANES-1:0] dqs_rise = dqs_s2_ff & ~dqs_s3_ff;
   // a rise that we drove ourselves reaches dqs_s2_ff two edges late,
   // after wr_ff has dropped, so the delayed drive flag masks it
   wire [LANES-1:0] rd_rise  = dqs_rise & ~{LANES{own_s2_ff}};
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         dqs_s1_ff <= '0;
         dqs_s2_ff <= '0;
         dqs_s3_ff <= '0;
         dq_s1_ff  <= '0;
         dq_s2_ff  <= '0;
         rdat_ff   <= '0;
         rvld_ff   <= 1'b0;
      end else begin
         dqs_s1_ff <= i_data_strobe_p;
         dqs_s2_ff <= dqs_s1_ff;
         dqs_s3_ff <= dqs_s2_ff;
         dq_s1_ff  <= i_data_lines;
         dq_s2_ff  <= dq_s1_ff;
         rvld_ff   <= !wr_ff && (|rd_rise);
         for (int l = 0; l < LANES; l++) begin
            if (rd_rise[l] && !wr_ff) begin
               rdat_ff[l*8 +: 8] <= dq_s2_ff[l*8 +: 8];
            end
         end
      end
   end

   // pin outputs
   assign o_ca                      = ca_ff;
   assign o_rank_clk_gate           = cke_ff;
   assign o_termination_ctrl        = odt_ff;
   assign o_termination_supply_gate = vtt_ff;

   // clock pairs: only the pairs of the active mode toggle
   assign o_mem_clock_pair_p        = i_lp5_mode ? '0 : {RANKS{mclk_ff}};
   assign o_mem_clock_pair_n        = i_lp5_mode ? '0 : {RANKS{~mclk_ff}};
   assign o_lp_clock_pair_p         = i_lp5_mode ? {dcp_pkg::LP_CHANS{mclk_ff}} : '0;
   assign o_lp_clock_pair_n         = i_lp5_mode ? {dcp_pkg::LP_CHANS{~mclk_ff}} : '0;

   // write drive; strobe enable stays one cycle longer as postamble
   assign o_data_lines              = wdat_ff;
   assign o_data_lines_oe           = {LANES{wr_ff}};
   assign o_data_strobe_p           = {LANES{wr_ff & ~mclk_ff}};
   assign o_data_strobe_n           = {LANES{~(wr_ff & ~mclk_ff)}};
   assign o_data_strobe_oe          = {LANES{wr_ff | wr_d_ff}};

   // read results
   assign o_rd_data                 = rdat_ff;
   assign o_rd_valid                = rvld_ff;

endmodule : dcp_pin_if

// [dv/dcp_pin_if_checker.sv]
`timescale 1ns/10ps
// pin-level relations of the command, power, clock and write paths
module dcp_pin_if_checker #(
   parameter int RANKS = 2,
   parameter int LANES = 8
) (
   input wire logic                   i_ref_clk,
   input wire logic                   i_arst_n,
   input wire logic                   i_lp5_mode,
   input wire dcp_pkg::dcp_req_t      i_req,
   input wire dcp_pkg::dcp_pwr_t      i_pwr,
   input wire logic                   i_wr_en,
   input wire logic [LANES*8-1:0]     i_wr_data,
   input wire dcp_pkg::dcp_ca_t       o_ca,
   input wire logic [RANKS-1:0]       o_rank_clk_gate,
   input wire logic                   o_termination_supply_gate,
   input wire logic [RANKS-1:0]       o_mem_clock_pair_p,
   input wire logic [3:0]             o_lp_clock_pair_p,
   input wire logic [LANES-1:0][7:0]  o_data_lines,
   input wire logic [LANES-1:0]       o_data_strobe_oe
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   // strobes driven for two cycles of a write
   sequence strobe_burst_s;
      o_data_strobe_oe == '1 ##1 o_data_strobe_oe == '1;
   endsequence
   rd_code_a: assert property (i_req.cmd == dcp_pkg::DCP_RD |=>
      o_ca.command_kind_flag && o_ca.row_col_lines[16:14] == 3'h5) else $error("read code");
   act_flag_a: assert property (i_req.cmd == dcp_pkg::DCP_ACT |=>
      !o_ca.command_kind_flag && o_ca.row_col_lines == $past(i_req.addr)) else $error("act");
   grp_sel_a: assert property (i_req.cmd == dcp_pkg::DCP_PRE |=>
      o_ca.group_select == $past(i_req.group)) else $error("group select");
   bank_sel_a: assert property (i_req.cmd == dcp_pkg::DCP_WR |=>
      o_ca.array_select == $past(i_req.bank)) else $error("bank select");
   gate_off_a: assert property (i_pwr.self_refresh |=> o_rank_clk_gate == '0)
      else $error("clock gate");
   lp_sel_a: assert property (i_lp5_mode && i_req.cmd == dcp_pkg::DCP_RD |=>
      o_ca.rank_select == 2'h1 << $past(i_req.rank[0])) else $error("rank select");
   vtt_off_a: assert property (i_pwr.deep_idle || i_pwr.suspend_to_ram |=>
      !o_termination_supply_gate) else $error("supply gate");
   ddr_clk_a: assert property (!i_lp5_mode [*3] |-> o_lp_clock_pair_p == '0 &&
      o_mem_clock_pair_p != $past(o_mem_clock_pair_p)) else $error("rank clock");
   lp_clk_a: assert property (i_lp5_mode [*3] |-> o_mem_clock_pair_p == '0 &&
      o_lp_clock_pair_p != $past(o_lp_clock_pair_p)) else $error("channel clock");
   wr_strobe_a: assert property (i_wr_en |=> strobe_burst_s) else $error("strobe");
   wr_data_a: assert property (i_wr_en |=> o_data_lines == $past(i_wr_data))
      else $error("write data");
endmodule : dcp_pin_if_checker

// [dv/dcp_mem_model.sv]
`timescale 1ns/10ps
// memory device answering one read burst
module dcp_mem_model (
   input  wire logic        i_clk,
   input  wire logic        i_go,
   input  wire logic [3:0]  i_wait,
   input  wire logic [63:0] i_word,
   input  wire logic [63:0] i_ctl_dq,
   input  wire logic [7:0]  i_ctl_oe,
   input  wire logic [7:0]  i_ctl_dqs,
   input  wire logic [7:0]  i_ctl_dqs_oe,
   output logic      [63:0] o_pin_dq,
   output logic      [7:0]  o_pin_dqs
);
   logic [63:0] drv = '0;
   logic [7:0]  dqs = '0;
   logic        on  = 1'b0;
   // one strobe edge, phase unrelated to i_clk
   always @(posedge i_go) begin
      repeat (i_wait) @(posedge i_clk);
      drv = i_word;
      on = 1'b1;
      #137 dqs = '1;
      #200 dqs = '0;
      #200 on = 1'b0;
   end
   // wire levels; released lanes show the inverse
   always_comb
      for (int l = 0; l < 8; l++)
         o_pin_dq[l*8+:8] = i_ctl_oe[l] ? i_ctl_dq[l*8+:8] : on ? drv[l*8+:8] : ~drv[l*8+:8];
   assign o_pin_dqs = i_ctl_dqs_oe ? i_ctl_dqs : dqs;
endmodule : dcp_mem_model

// [dv/dcp_pin_if_tb.sv]
`timescale 1ns/10ps
module dcp_pin_if_tb;
   localparam logic [2:0] ENC [7] = '{3'h7, 3'h0, 3'h5, 3'h4, 3'h2, 3'h0, 3'h1};
   logic              i_ref_clk = 1'b0, i_arst_n = 1'b0, i_lp5_mode = 1'b0, i_wr_en = 1'b0;
   dcp_pkg::dcp_req_t i_req = '0;
   dcp_pkg::dcp_pwr_t i_pwr = 6'h01;
   logic [1:0]        i_odt_req = 2'h0, o_rank_clk_gate, o_termination_ctrl;
   logic [1:0]        o_mem_clock_pair_p, o_mem_clock_pair_n;
   logic [3:0]        o_lp_clock_pair_p, o_lp_clock_pair_n, rd_wait = 4'h0;
   logic [63:0]       i_wr_data = '0, o_rd_data, rd_word = '0;
   logic [7:0][7:0]   i_data_lines, o_data_lines;
   logic [7:0]        i_data_strobe_p, o_data_strobe_p, o_data_strobe_n, o_data_strobe_oe;
   logic [7:0]        o_data_lines_oe;
   logic              o_rd_valid, o_termination_supply_gate, rd_go = 1'b0;
   dcp_pkg::dcp_ca_t  o_ca;
   int                n_mismatch = 0, n_compared = 0;

   always #25 i_ref_clk = ~i_ref_clk;
   dcp_pin_if dcp_pin_if_inst (.*);
   dcp_mem_model dcp_mem_model_inst (.i_clk(i_ref_clk), .i_go(rd_go), .i_wait(rd_wait),
      .i_word(rd_word), .i_ctl_dq(o_data_lines), .i_ctl_oe(o_data_lines_oe),
      .i_ctl_dqs(o_data_strobe_p), .i_ctl_dqs_oe(o_data_strobe_oe),
      .o_pin_dq(i_data_lines), .o_pin_dqs(i_data_strobe_p));

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic step();
      @(posedge i_ref_clk);
      #1;
   endtask : step
   // every command back to back in both modes
   task automatic t_cmd();
      dcp_pkg::dcp_cmd_t c;
      for (int m = 0; m < 2; m++) begin
         for (int k = 0; k < 7; k++) begin
            c = dcp_pkg::dcp_cmd_t'(k);
            i_lp5_mode = m[0];
            i_req = '{c, 2'(k), 2'h3, 2'h2, 17'h1_2345 + 17'(k)};
            step();
            chk(o_ca.command_kind_flag, c != dcp_pkg::DCP_ACT);
            chk(o_ca.row_col_lines[16:14], k == 1 ? i_req.addr[16:14] : ENC[k]);
            if (k > 0 && k < 6) begin
               chk(o_ca.group_select, c == dcp_pkg::DCP_MRS ? 2'h1 : 2'h3);
               chk(o_ca.array_select, 2'h2);
            end
            chk(o_ca.rank_select, k == 0 ? {2{!m[0]}} :
               2'(m[0] ? 2'h1 << k[0] : ~(2'h1 << k[0])));
            chk({o_mem_clock_pair_n, o_lp_clock_pair_n},
               m[0] ? {2'h0, ~o_lp_clock_pair_p} : {~o_mem_clock_pair_p, 4'h0});
         end
      end
   endtask : t_cmd
   // power states: clock gates, termination and its supply
   task automatic t_pwr();
      dcp_pkg::dcp_pwr_t p [7] = '{6'h01, 6'h03, 6'h05, 6'h21, 6'h09, 6'h11, 6'h00};
      logic [1:0] g;
      for (int i = 0; i < 7; i++) begin
         i_pwr = p[i];
         i_odt_req = 2'(i + 1);
         step();
         g = (!i_pwr.init_done || i_pwr.self_refresh || i_pwr.suspend_to_ram) ?
            2'h0 : ~i_pwr.power_down;
         chk(o_rank_clk_gate, g);
         chk(o_termination_ctrl, g & i_odt_req);
         chk(o_termination_supply_gate, !(i_pwr.deep_idle || i_pwr.suspend_to_ram));
      end
      i_pwr = 6'h01;
   endtask : t_pwr
   // write drives all lanes and strobes
   task automatic t_wr();
      i_lp5_mode = 1'b0;
      i_wr_en = 1'b1;
      i_wr_data = 64'h0123_4567_89ab_cdef;
      step();
      i_wr_en = 1'b0;
      chk(o_data_lines, i_wr_data);
      chk(o_data_lines_oe, 8'hff);
      chk(o_data_strobe_oe, 8'hff);
      chk(o_data_strobe_n, 8'(~o_data_strobe_p));
      step();
      chk(o_data_strobe_oe, 8'hff);
      chk({o_data_strobe_p, o_data_strobe_n, o_data_lines_oe}, 24'h00_ff00);
   endtask : t_wr
   // read captured on the device's strobe
   task automatic t_rd(input logic [3:0] w);
      int k;
      rd_wait = w;
      rd_word = 64'hfeed_0000_0000_beef ^ 64'(w);
      step(); // word and wait settle before the model is started
      rd_go = 1'b1;
      step();
      rd_go = 1'b0;
      for (k = 0; k < 40 && o_rd_valid !== 1'b1; k++) step();
      chk(k < 40, 1'b1);
      chk(o_rd_data, rd_word);
      repeat (20) step();
   endtask : t_rd
   // mid-run reset idles every pin group, then the first edge takes a command
   task automatic t_rst();
      i_arst_n = 1'b0;
      i_lp5_mode = 1'b0;
      step();
      chk({o_ca, o_rank_clk_gate, o_termination_ctrl, o_termination_supply_gate}, '0);
      chk({o_mem_clock_pair_p, o_mem_clock_pair_n, o_lp_clock_pair_n}, 8'h30);
      chk({o_data_lines_oe, o_data_strobe_oe, o_rd_valid}, '0);
      i_arst_n = 1'b1;
      i_req = '{dcp_pkg::DCP_RD, 2'h1, 2'h0, 2'h1, 17'h0_0000};
      step();
      chk({o_ca.command_kind_flag, o_ca.row_col_lines[16:14], o_ca.rank_select}, 6'h35);
   endtask : t_rst
   task automatic finish_test();
      if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   initial begin
      repeat (10) @(posedge i_ref_clk);
      #1 i_arst_n = 1'b1;
      t_cmd();
      t_pwr();
      t_rst();
      t_wr();
      t_rd(4'h0);
      t_rd(4'h5);
      finish_test();
   end
   initial begin
      #20000;
      n_mismatch++;
      finish_test();
   end
endmodule : dcp_pin_if_tb

bind dcp_pin_if dcp_pin_if_checker #(.RANKS(RANKS), .LANES(LANES)) dcp_pin_if_checker_inst (.*);
